//--- core/sadc_clkdiv.sv
// converter clock prescaler producing a one-cycle tick
module sadc_clkdiv
   import sadc_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [2:0] div_sel,
   output logic            tick
);
   // ==========================================
   // divide ratio decode
   // ==========================================
   logic [3:0] cnt_reg; // cycles since last tick
   logic [3:0] limit;   // terminal count

   // a tick every (limit+1) bus clocks
   always_comb begin
      unique case (div_sel[1:0])
         2'h0:    limit = 4'h0;
         2'h1:    limit = 4'h1;
         2'h2:    limit = 4'h3;
         default: limit = 4'h7;
      endcase
      if (div_sel[2]) begin
         limit = 4'hF; // 1xx divides by 16
      end
   end

   // >= so a smaller ratio written mid-count recovers at once
   assign tick = (cnt_reg >= limit);

   // free-running counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= 4'h0;
      end else if (tick) begin
         cnt_reg <= 4'h0;
      end else begin
         cnt_reg <= cnt_reg + 4'h1;
      end
   end

   div_two_a: assert property (@(posedge pclk) disable iff (!presetn)
      (tick && div_sel == 3'h1) ##1 (div_sel == 3'h1) ##1 (div_sel == 3'h1)
      |-> tick && !$past(tick))
      else $error("divide by two tick spacing wrong");
endmodule

//--- core/sadc_sar.sv
// successive approximation sequencer, sixteen converter clocks per result
module sadc_sar
   import sadc_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       tick,
   input  wire logic       start,
   input  wire logic       abort,
   input  wire logic       cmp_hi,
   output logic            busy,
   output logic            done,
   output logic [7:0]      trial,
   output logic [7:0]      result
);
   // ==========================================
   // sequencer state
   // ==========================================
   logic [3:0] step_reg; // converter clocks spent
   logic [7:0] bits_reg; // resolved bits
   logic [7:0] mask_reg; // bit under test
   logic       busy_reg; // conversion running
   logic [4:0] ticks_h;  // check-only tick count

   assign busy = busy_reg;
   // last decision folds in directly so the result lands on step 15
   assign done   = busy_reg & tick & (step_reg == SADC_LAST_STEP) & ~abort;
   assign trial  = bits_reg | mask_reg;
   assign result = bits_reg | (cmp_hi ? mask_reg : SADC_ZERO);

   // run flag: abort wins over start
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_reg <= 1'b0;
      end else if (abort) begin
         busy_reg <= 1'b0;
      end else if (start) begin
         busy_reg <= 1'b1;
      end else if (done) begin
         busy_reg <= 1'b0;
      end
   end

   // step counter: the first tick after the start tick is clock one of sixteen
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         step_reg <= 4'h0;
      end else if (start) begin
         step_reg <= 4'h0;
      end else if (busy_reg && tick) begin
         step_reg <= step_reg + 4'h1;
      end
   end

   // msb first, one decision per clock in the second half
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bits_reg <= SADC_ZERO;
         mask_reg <= SADC_MSB_MASK;
      end else if (start) begin
         bits_reg <= SADC_ZERO;
         mask_reg <= SADC_MSB_MASK;
      end else if (busy_reg && tick && step_reg >= SADC_FIRST_BIT) begin
         // comparator high keeps the bit, so out-of-range clamps
         bits_reg <= bits_reg | (cmp_hi ? mask_reg : SADC_ZERO);
         mask_reg <= mask_reg >> 1;
      end
   end

   // independent tick count for checking
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ticks_h <= 5'h00;
      end else if (start) begin
         ticks_h <= 5'h00;
      end else if (busy_reg && tick) begin
         ticks_h <= ticks_h + 5'h01;
      end
   end

   conv_length_a: assert property (@(posedge pclk) disable iff (!presetn)
      done |-> ticks_h == SADC_TICKS_END)
      else $error("conversion did not take sixteen clocks");

   msb_first_a: assert property (@(posedge pclk) disable iff (!presetn)
      (busy_reg && tick && !start && step_reg >= SADC_FIRST_BIT && step_reg < SADC_LAST_STEP)
      |=> mask_reg == ($past(mask_reg) >> 1))
      else $error("approximation mask did not step down");
endmodule

//--- core/sadc_top.sv
// converter control: apb registers, conversion sequencing and pin takeover
//
// Overview of operation
// - one result takes sixteen converter clocks
// - conversion starts next converter clock after write
// - eight-bit result written to result register
// - over-range clamps FF, under-range clamps 00
// - continuous mode overwrites result every conversion
// - done flag set per result, read clears
// - irq enable raises interrupt, done stays 0
// - four channels on port a, one selected
// - selected pin forced input, port writes ignored
// - claimed pin reads 0 or data latch
// - unselected shared pins stay normal port pins
// - keeps running in wait, irq wakes
// - stop aborts conversion, resumes after stop
// - channel codes 0..3, all ones powers off
// - prescaler divides bus clock by 1..16
// - irq clears on result read or status/control write
module sadc_top
   import sadc_pkg::*;
(
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [7:0]          paddr,
   input  wire logic [31:0]         pwdata,
   output logic [31:0]              prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic                stop_mode,
   input  wire logic                cmp_hi,
   output sadc_ana_t                ana,
   output logic                     conv_irq,
   input  wire logic [SADC_NCH-1:0] port_pin_in,
   output logic [SADC_NCH-1:0]      port_pin_out,
   output logic [SADC_NCH-1:0]      port_pin_oe
);
   // ==========================================
   // declarations
   // ==========================================
   sadc_ctrl_t          ctrl_reg;   // software control fields
   logic [2:0]          div_reg;    // clock_divider_field
   logic [7:0]          result_reg; // last finished result
   logic                done_reg;   // conversion_done_flag
   logic                irq_reg;    // interrupt request
   logic                pend_reg;   // start waiting for a tick
   logic [SADC_NCH-1:0] pdat_reg;   // port data latch
   logic [SADC_NCH-1:0] pdir_reg;   // port direction, 1 = out
   logic                ready_reg;  // apb wait-state flag
   logic [31:0]         prdata_reg; // captured read data
   logic                err_reg;    // captured decode error

   logic                xfer;       // apb transfer completes
   logic                wr_en;      // completing write
   logic                rd_en;      // completing read
   logic                scr_wr;     // status/control written
   logic                res_rd;     // result read
   logic                hit;        // address decodes
   logic [31:0]         rd_mux;     // read data select
   logic [SADC_NCH-1:0] claim;      // pins owned by converter
   logic [SADC_NCH-1:0] port_view;  // port read value
   logic                pwr_on;     // analog section on
   logic                tick;       // converter clock edge
   logic                sar_start;  // begin a conversion
   logic                sar_abort;  // kill running conversion
   logic                sar_busy;   // conversion running
   logic                sar_done;   // conversion finished
   logic [7:0]          sar_trial;  // trial code to dac
   logic [7:0]          sar_res;    // finished code
   logic [4:0]          wr_ch;      // channel being written

   // ==========================================
   // apb slave: one wait state per transfer
   // ==========================================
   // the wait state lets read data come from a flop
   assign xfer   = psel & penable & ready_reg;
   assign wr_en  = xfer & pwrite;
   assign rd_en  = xfer & ~pwrite;
   assign scr_wr = wr_en & (paddr == SADC_SCR_OFF);
   assign res_rd = rd_en & (paddr == SADC_RES_OFF);
   assign wr_ch  = pwdata[SADC_CH_MSB:0];

   assign pready  = ready_reg;
   assign prdata  = prdata_reg;
   assign pslverr = ready_reg & err_reg;

   // address decode
   always_comb begin
      unique case (paddr)
         SADC_SCR_OFF, SADC_RES_OFF, SADC_CLK_OFF,
         SADC_PDAT_OFF, SADC_PDIR_OFF: hit = 1'b1;
         default:                      hit = 1'b0;
      endcase
   end

   // read data select, unused bits read zero
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (paddr)
         SADC_SCR_OFF: begin
            // done never shows while irq mode is on
            rd_mux[SADC_DONE_BIT] = done_reg & ~ctrl_reg.ien;
            rd_mux[SADC_IEN_BIT]  = ctrl_reg.ien;
            rd_mux[SADC_CONT_BIT] = ctrl_reg.cont;
            rd_mux[SADC_CH_MSB:0] = ctrl_reg.ch;
         end
         SADC_RES_OFF:  rd_mux[7:0] = result_reg;
         SADC_CLK_OFF:  rd_mux[2:0] = div_reg;
         SADC_PDAT_OFF: rd_mux[SADC_NCH-1:0] = port_view;
         SADC_PDIR_OFF: rd_mux[SADC_NCH-1:0] = pdir_reg;
         default:       rd_mux = 32'h0000_0000;
      endcase
   end

   // ready toggles so each access phase lasts two cycles
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ready_reg <= 1'b0;
      end else begin
         ready_reg <= psel & penable & ~ready_reg;
      end
   end

   // read data and error captured in the first access cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= 32'h0000_0000;
         err_reg    <= 1'b0;
      end else if (psel && penable && !ready_reg) begin
         prdata_reg <= pwrite ? 32'h0000_0000 : rd_mux;
         err_reg    <= ~hit;
      end
   end

   // ==========================================
   // control registers
   // ==========================================
   // written done bit is dropped; software keeps it zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg.ien  <= 1'b0;
         ctrl_reg.cont <= 1'b0;
         ctrl_reg.ch   <= SADC_CH_RST;
      end else if (scr_wr) begin
         ctrl_reg.ien  <= pwdata[SADC_IEN_BIT];
         ctrl_reg.cont <= pwdata[SADC_CONT_BIT];
         ctrl_reg.ch   <= wr_ch;
      end
   end

   // prescaler select
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_reg <= SADC_DIV_RST;
      end else if (wr_en && paddr == SADC_CLK_OFF) begin
         div_reg <= pwdata[2:0];
      end
   end

   // ==========================================
   // converter clock and sequencer
   // ==========================================
   sadc_clkdiv u_div (
      .pclk    (pclk),
      .presetn (presetn),
      .div_sel (div_reg),
      .tick    (tick)
   );

   // all ones switches the analog section off
   assign pwr_on = (ctrl_reg.ch != SADC_CH_OFF) & ~stop_mode;

   // a write restarts; stop kills the conversion
   assign sar_abort = scr_wr | stop_mode;
   // first tick after the write starts it
   assign sar_start = tick & pend_reg & pwr_on & ~sar_abort;

   // pending start request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_reg <= 1'b0;
      end else if (scr_wr) begin
         pend_reg <= (wr_ch != SADC_CH_OFF);
      end else if (sar_done && ctrl_reg.cont) begin
         pend_reg <= 1'b1;
      end else if (stop_mode && sar_busy) begin
         // remember the aborted run so it resumes after stop
         pend_reg <= 1'b1;
      end else if (sar_start) begin
         pend_reg <= 1'b0; // single mode idles here
      end
   end

   sadc_sar u_sar (
      .pclk    (pclk),
      .presetn (presetn),
      .tick    (tick),
      .start   (sar_start),
      .abort   (sar_abort),
      .cmp_hi  (cmp_hi),
      .busy    (sar_busy),
      .done    (sar_done),
      .trial   (sar_trial),
      .result  (sar_res)
   );

   // analog side; first result after stop or power-up may be off
   always_comb begin
      ana.pwr_on = pwr_on;
      ana.busy   = sar_busy;
      ana.sel    = ctrl_reg.ch;
      ana.trial  = sar_trial;
   end

   // ==========================================
   // result, done flag and interrupt
   // ==========================================
   // overwritten every conversion, read or not
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result_reg <= SADC_RES_RST;
      end else if (sar_done) begin
         result_reg <= sar_res;
      end
   end

   // set wins over the clearing read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         done_reg <= 1'b0;
      end else if (sar_done && !ctrl_reg.ien) begin
         done_reg <= 1'b1;
      end else if (res_rd || ctrl_reg.ien) begin
         done_reg <= 1'b0;
      end
   end

   // irq not gated by wait, so it can wake the core
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_reg <= 1'b0;
      end else if (sar_done && ctrl_reg.ien) begin
         irq_reg <= 1'b1;
      end else if (res_rd || scr_wr) begin
         irq_reg <= 1'b0;
      end
   end

   assign conv_irq = irq_reg;

   // ==========================================
   // shared port a pins
   // ==========================================
   // index 0..3 are the port pins bit0, bit1, bit4, bit5
   always_comb begin
      claim = '0;
      if (ctrl_reg.ch < 5'(SADC_NCH)) begin
         claim[ctrl_reg.ch[1:0]] = 1'b1;
      end
   end

   // claimed bit keeps its old latch value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pdat_reg <= SADC_PORT_RST;
         pdir_reg <= SADC_PORT_RST;
      end else if (wr_en && paddr == SADC_PDAT_OFF) begin
         pdat_reg <= (pdat_reg & claim) | (pwdata[SADC_NCH-1:0] & ~claim);
      end else if (wr_en && paddr == SADC_PDIR_OFF) begin
         pdir_reg <= (pdir_reg & claim) | (pwdata[SADC_NCH-1:0] & ~claim);
      end
   end

   // pin drive: converter forces its pin to input
   assign port_pin_out = pdat_reg;
   assign port_pin_oe  = pdir_reg & ~claim;

   // read view per pin
   always_comb begin
      for (int i = 0; i < SADC_NCH; i++) begin
         if (claim[i]) begin
            port_view[i] = pdir_reg[i] & pdat_reg[i];
         end else begin
            port_view[i] = pdir_reg[i] ? pdat_reg[i] : port_pin_in[i];
         end
      end
   end

   // ==========================================
   // checks
   // ==========================================
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence start_req_s;
      scr_wr && wr_ch != SADC_CH_OFF && !stop_mode;
   endsequence

   sequence quiet_s;
      !scr_wr && !stop_mode;
   endsequence

   start_follows_a: assert property (
      start_req_s ##1 quiet_s[*1] |-> ##[0:16] sar_start)
      else $error("no start after control write");

   result_load_a: assert property (
      sar_done |=> result_reg == $past(sar_res))
      else $error("result register not loaded");

   cont_repeat_a: assert property (
      (sar_done && ctrl_reg.cont) and quiet_s |=> pend_reg)
      else $error("continuous mode did not rearm");

   done_set_a: assert property (
      sar_done && !ctrl_reg.ien |=> done_reg ##0 !res_rd[*1] |=> done_reg)
      else $error("done flag not set or not held");

   irq_mode_a: assert property (
      sar_done && ctrl_reg.ien |=> conv_irq && !done_reg)
      else $error("irq mode misbehaves");

   pin_input_a: assert property (
      (claim & port_pin_oe) == '0)
      else $error("claimed pin is driven");

   stop_abort_a: assert property (
      stop_mode |=> !sar_busy)
      else $error("conversion survives stop");

   irq_clear_a: assert property (
      (res_rd || scr_wr) && !sar_done |=> !conv_irq)
      else $error("irq not cleared");

   power_off_a: assert property (
      ctrl_reg.ch == SADC_CH_OFF |-> !sar_start && !ana.pwr_on)
      else $error("converter runs while powered off");

   single_idle_a: assert property (
      (sar_done && !ctrl_reg.cont) and quiet_s |=> !pend_reg ##1 !sar_busy)
      else $error("single mode did not stop");
endmodule

//--- inc/sadc_pkg.sv
// shared constants and types for the converter control block
package sadc_pkg;
   // ==========================================
   // register byte offsets on the apb slave
   // ==========================================
   localparam logic [7:0] SADC_SCR_OFF  = 8'h3C; // converter_status_control
   localparam logic [7:0] SADC_RES_OFF  = 8'h40; // conversion result
   localparam logic [7:0] SADC_CLK_OFF  = 8'h44; // converter_clock_select
   localparam logic [7:0] SADC_PDAT_OFF = 8'h48; // port a data latch
   localparam logic [7:0] SADC_PDIR_OFF = 8'h4C; // port a direction

   // ==========================================
   // status and control field positions
   // ==========================================
   localparam int SADC_DONE_BIT = 7; // conversion_done_flag
   localparam int SADC_IEN_BIT  = 6; // conversion_irq_enable
   localparam int SADC_CONT_BIT = 5; // continuous_convert_bit
   localparam int SADC_CH_MSB   = 4; // input_select_field top

   // ==========================================
   // values after reset and special codes
   // ==========================================
   localparam logic [4:0] SADC_CH_OFF   = 5'h1F; // power-down code
   localparam logic [4:0] SADC_CH_RST   = 5'h1F;
   localparam logic [2:0] SADC_DIV_RST  = 3'h0;
   localparam logic [3:0] SADC_PORT_RST = 4'h0;
   localparam logic [7:0] SADC_RES_RST  = 8'h00;
   localparam int         SADC_NCH      = 4;     // shared pins

   // ==========================================
   // conversion timing in converter clocks
   // ==========================================
   localparam logic [3:0] SADC_LAST_STEP = 4'hF; // sixteen clocks
   localparam logic [3:0] SADC_FIRST_BIT = 4'h8; // decisions 8..15
   localparam logic [4:0] SADC_TICKS_END = 5'h0F;
   localparam logic [7:0] SADC_MSB_MASK  = 8'h80;
   localparam logic [7:0] SADC_ZERO      = 8'h00;

   // control fields held by software
   typedef struct packed {
      logic       ien;  // irq instead of done flag
      logic       cont; // repeat conversions
      logic [4:0] ch;   // channel or power-down
   } sadc_ctrl_t;

   // signals to the analog mux and comparator
   typedef struct packed {
      logic       pwr_on; // analog section enabled
      logic       busy;   // conversion running
      logic [4:0] sel;    // mux select
      logic [7:0] trial;  // dac trial code
   } sadc_ana_t;
endpackage

//--- tb/sadc_ana_model.sv
// analog mux and comparator stand-in for the converter bench
module sadc_ana_model
   import sadc_pkg::*;
(
   input  wire logic       pclk,
   input  wire sadc_ana_t  ana,
   input  wire logic [7:0] code,   // clamped digital image of the input
   output logic            cmp_hi
);
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================
   // comparator
   // ==========================================
   logic last_reg = 1'b0; // last decision
   // decide against the trial code; idle output toggles so no stale level
   assign cmp_hi = (ana.pwr_on && ana.busy) ? (code >= ana.trial) : ~last_reg;
   // remember the decision each cycle
   always_ff @(posedge pclk) last_reg <= cmp_hi;
endmodule

//--- tb/sadc_top_bench.sv
// self-checking bench for the converter control block
module sadc_top_bench;
   import sadc_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   // ==========================================
   // stimulus and wiring
   // ==========================================
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, stop_mode = 0;
   logic [7:0]  paddr = 0, code = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic        pready, pslverr, cmp_hi, conv_irq, er;
   logic [3:0]  pin_in = 0, pin_out, pin_oe;
   sadc_ana_t   ana;
   int          num_errors = 0, checked = 0, n;
   sadc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .stop_mode(stop_mode), .cmp_hi(cmp_hi), .ana(ana),
      .conv_irq(conv_irq), .port_pin_in(pin_in), .port_pin_out(pin_out), .port_pin_oe(pin_oe));
   sadc_ana_model model (.pclk(pclk), .ana(ana), .code(code), .cmp_hi(cmp_hi));
   // 20 MHz bus clock
   initial forever #25 pclk = ~pclk;
   // ==========================================
   // shared tasks
   // ==========================================
   task chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         num_errors++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // one apb transfer; idle cycle first so strobes never change twice per step
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1;
      // wait as long as the slave needs; only the watchdog ends a hang
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rd, e);
   endtask
   // busy cycles seen over a window
   task busy_cnt(input int w);
      n = 0;
      repeat (w) begin
         @(posedge pclk);
         if (ana.busy === 1'b1) n++;
      end
   endtask
   task finish_test;
      $display("checked %0d num_errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // ==========================================
   // scenarios
   // ==========================================
   task t_reset;
      rdc(SADC_SCR_OFF, 32'h1F);
      rdc(SADC_RES_OFF, 32'h0);
      rdc(SADC_CLK_OFF, 32'h0);
      rdc(SADC_PDIR_OFF, 32'h0);
      apb(1'b0, 8'h50, 32'h0);
      chk(er, 1'b1);
      chk(rd, 32'h0);
      $display("test reset done");
   endtask
   // every prescaler code, single mode, done flag life
   task t_div;
      int d;
      for (int k = 0; k < 8; k++) begin
         d = (k > 3) ? 16 : (1 << k);
         code <= 8'h5A + 8'(k);
         wr(SADC_CLK_OFF, 32'(k));
         wr(SADC_SCR_OFF, 32'h0);
         busy_cnt(300);
         chk(n, 16 * d);
         rdc(SADC_SCR_OFF, 32'h80);
         rdc(SADC_RES_OFF, 32'h5A + k);
         rdc(SADC_SCR_OFF, 32'h0);
      end
      wr(SADC_CLK_OFF, 32'h0);
      $display("test divider done");
   endtask
   task t_irq;
      code <= 8'hFF;
      wr(SADC_SCR_OFF, 32'h41);
      busy_cnt(30);
      chk(conv_irq, 1'b1);
      rdc(SADC_SCR_OFF, 32'h41);
      rdc(SADC_RES_OFF, 32'hFF);
      @(posedge pclk);
      chk(conv_irq, 1'b0);
      wr(SADC_SCR_OFF, 32'h41);
      busy_cnt(30);
      chk(conv_irq, 1'b1);
      wr(SADC_SCR_OFF, 32'h5F);
      @(posedge pclk);
      chk(conv_irq, 1'b0);
      $display("test irq done");
   endtask
   task t_cont;
      code <= 8'h00;
      wr(SADC_SCR_OFF, 32'h20);
      busy_cnt(20);
      rdc(SADC_SCR_OFF, 32'hA0);
      rdc(SADC_RES_OFF, 32'h0);
      code <= 8'h33;
      busy_cnt(40);
      chk(n > 30, 1'b1);
      rdc(SADC_RES_OFF, 32'h33);
      // power down mid-conversion; the cut result is never read
      wr(SADC_SCR_OFF, 32'h1F);
      $display("test continuous done");
   endtask
   task t_stop;
      code <= 8'h77;
      wr(SADC_SCR_OFF, 32'h0);
      repeat (5) @(posedge pclk);
      stop_mode <= 1;
      repeat (2) @(posedge pclk);
      chk(ana.busy, 1'b0);
      chk(ana.pwr_on, 1'b0);
      stop_mode <= 0;
      busy_cnt(40);
      chk(n, 16);
      // first result after stop is thrown away; convert once more
      wr(SADC_SCR_OFF, 32'h0);
      busy_cnt(20);
      rdc(SADC_RES_OFF, 32'h77);
      $display("test stop done");
   endtask
   task t_port;
      pin_in <= 4'b0101;
      // release every pin first so the port writes all land
      wr(SADC_SCR_OFF, 32'h1F);
      wr(SADC_PDIR_OFF, 32'hF);
      wr(SADC_PDAT_OFF, 32'hF);
      wr(SADC_SCR_OFF, 32'h02);
      @(posedge pclk);
      chk(ana.sel, 5'h02);
      chk(pin_oe, 4'b1011);
      rdc(SADC_PDAT_OFF, 32'hF);
      wr(SADC_PDAT_OFF, 32'h0);
      @(posedge pclk);
      chk(pin_out, 4'b0100);
      wr(SADC_PDIR_OFF, 32'h0);
      rdc(SADC_PDAT_OFF, 32'h5);
      // claimed pin with direction 0 reads zero despite latch 1
      wr(SADC_SCR_OFF, 32'h1F);
      wr(SADC_PDIR_OFF, 32'h0);
      wr(SADC_SCR_OFF, 32'h02);
      rdc(SADC_PDAT_OFF, 32'h1);
      $display("test port done");
   endtask
   // ==========================================
   // main sequence and watchdog
   // ==========================================
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1;
      t_reset();
      t_div();
      t_irq();
      t_cont();
      t_stop();
      t_port();
      finish_test();
   end
   // whole run needs well under 10000 cycles
   initial begin
      #(50 * 20000);
      num_errors++;
      finish_test();
   end
endmodule
